// file: src/hop_encoder.sv
/*
 * code hopping encoder: parameter store, word builder, bit fifo,
 * pulse-width serialiser and externally clocked transmission.
 * assumes button and supply comparator inputs are asynchronous, the pwm pin
 * is pulled low outside and the rf stage samples the pwm level.
 */
// Overview of operation
// - store is 12 words of 16 bits
// - fixed word map for key, counter, serial
// - hop counter advances each transmission except seed words
// - only serial low 28 bits sent
// - all three buttons send seed
// - option word fields: disc, threshold, rate
// - encrypted part: buttons, disc, counter enciphered
// - fixed part: fixed, status, buttons, serial
// - preamble, header, 66 data bits, guard
// - rate bit picks element and blanking
// - threshold bit selects supply trip comparator
// - start-up plus low button enters clocked mode
// - clocked mode appends 16 reserved bits
// - clocked mode buttons sampled at entry
// - started word completes despite release
// - held button repeats transmissions
// - new button aborts and rebuilds word outside clocked mode
// - wake, debounce 10 ms, then build
// - low supply flag one below threshold
`timescale 1ns/1ns
`include "hop_encoder_map.svh"

module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             flush,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              do_push = in_valid && in_ready;
    wire              do_pop  = out_valid && out_ready;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= do_push ? wr_q + 1'b1 : wr_q;
            rd_q  <= do_pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

module hop_encoder #(
    parameter int unsigned ELEM_SLOW_CYC = `ELEM_SLOW_US * `CLK_MHZ,
    parameter int unsigned ELEM_FAST_CYC = `ELEM_FAST_US * `CLK_MHZ,
    parameter int unsigned DEBOUNCE_CYC  = `DEBOUNCE_US * `CLK_MHZ,
    parameter int unsigned PROG_SETUP_CYC = `PROG_SETUP_US * `CLK_MHZ
) (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    // buttons, third one doubles as outside bit clock
    input  wire logic                        button_input_a,
    input  wire logic                        button_input_b,
    input  wire logic                        button_input_c_clock,
    // pwm pin
    input  wire logic                        pwm_in,
    output hop_encoder_pkg::pin_drive_t      pwm_pin,
    // supply comparators, high when supply is below the trip
    input  wire logic                        below_trip_6v,
    input  wire logic                        below_trip_9v,
    // status
    output logic                             powered_up
);
    import hop_encoder_pkg::*;

    // input synchronisers
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {below_trip_9v, below_trip_6v, pwm_in,
                        button_input_c_clock, button_input_b, button_input_a};
            sync2_q <= sync1_q;
        end
    end
    wire [2:0] btn_now  = sync2_q[2:0];
    wire       clk_pin  = sync2_q[2];
    wire       data_pin = sync2_q[3];

    logic       clk_prev_q;
    wire        clk_rise = clk_pin && !clk_prev_q;
    wire        clk_fall = !clk_pin && clk_prev_q;

    // parameter store, nonvolatile so never reset
    logic [15:0] store_q [`STORE_WORDS];
    wire [63:0]  key    = {store_q[`W_KEY3], store_q[`W_KEY2],
                           store_q[`W_KEY1], store_q[`W_KEY0]};
    wire [15:0]  hop    = store_q[`W_HOP_COUNT];
    wire [31:0]  serial = {store_q[`W_SERIAL_HI], store_q[`W_SERIAL_LO]};
    wire [31:0]  seed   = {store_q[`W_SEED_HI], store_q[`W_SEED_LO]};
    wire [15:0]  option = store_q[`W_OPTION];
    wire [11:0]  discrimination_value = option[`OPT_DISC_MSB:0];
    wire supply_threshold_select = option[`OPT_VSEL_BIT];
    wire rate_select_bit         = option[`OPT_RATE_BIT];

    // nonlinear mixing stand-in; the real cipher is outside this block
    function automatic logic [31:0] encipher(input logic [31:0] x,
                                             input logic [63:0] k);
        logic [31:0] v;
        v = x;
        for (int i = 0; i < 64; i++) begin
            v = {v[30:0], v[31] ^ v[15] ^ (v[26] & v[9]) ^ k[i]};
        end
        return v;
    endfunction

    enc_state_t  state_q;
    enc_state_t  state_d;
    logic [23:0] wait_q;
    logic [23:0] elem_q;
    logic [7:0]  phase_q;
    logic [1:0]  sub_q;
    logic [6:0]  sent_q;
    logic [6:0]  load_q;
    logic [81:0] word_q;
    logic [2:0]  btn_q;
    logic        sync_mode_q;
    logic        blank_q;
    logic        pwm_q;
    logic        oe_n_q;
    logic [3:0]  prog_idx_q;
    logic [3:0]  prog_bit_q;
    logic [15:0] prog_sr_q;

    // element timing
    wire [23:0] elem_len = rate_select_bit ? 24'(ELEM_FAST_CYC - 1)
                                           : 24'(ELEM_SLOW_CYC - 1);
    wire tx_timed = state_q inside {ST_PREAMBLE, ST_HEADER, ST_DATA,
                                    ST_GUARD};
    wire elem_tick = tx_timed && (elem_q == elem_len);

    // word assembly
    wire        seed_req = (btn_q == `ALL_BUTTONS);
    wire [3:0]  btn_code = {btn_q[2], btn_q};
    wire        low_supply_flag = supply_threshold_select ? sync2_q[5]
                                                          : sync2_q[4];
    wire [15:0] hop_next = hop + 16'h0001;
    wire [31:0] plain    = {1'b0, btn_q, discrimination_value, hop_next};
    fixed_part_t fixed_part;
    assign fixed_part = '{fixed_one: 1'b1,
                          low_supply_flag: low_supply_flag,
                          buttons: btn_code,
                          serial: serial[`SERIAL_TX_BITS-1:0]};
    wire [31:0] hop_part = seed_req ? seed : encipher(plain, key);
    wire [81:0] word_new = {`EXTRA_BITS'(0), fixed_part, hop_part};

    // fifo between assembly and serialiser
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_bit;
    wire abort;
    wire push = (load_q != '0);
    wire bit_pop = sync_mode_q ? (state_q == ST_SYNC) && clk_rise
                               : (state_q == ST_DATA) && elem_tick
                                 && (sub_q == `SYMBOL_ELEMS);
    bit_fifo #(.WIDTH(1), .DEPTH(16)) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .flush     (abort),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (word_q[0]),
        .out_valid (fifo_out_valid),
        .out_ready (bit_pop),
        .out_data  (fifo_bit)
    );

    wire new_press = |(btn_now & ~btn_q);
    assign abort = tx_timed && !sync_mode_q && new_press;
    wire word_done = (state_q == ST_DATA) && bit_pop
                     && (sent_q == `DATA_BITS - 7'h01);

    // next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (btn_now != '0) state_d = ST_DEBOUNCE;
            ST_DEBOUNCE:
                if (btn_now == 3'h4 && data_pin
                    && wait_q >= 24'(PROG_SETUP_CYC)) begin
                    state_d = ST_ENTRY;
                end else if (wait_q == 24'(DEBOUNCE_CYC - 1)) begin
                    state_d = (btn_now == '0) ? ST_IDLE : ST_BUILD;
                end
            ST_ENTRY:
                if (clk_fall) state_d = (btn_now[1:0] != '0) ? ST_BUILD
                                                              : ST_PROG;
            ST_PROG:
                if (prog_idx_q == 4'(`STORE_WORDS)) state_d = ST_IDLE;
            ST_BUILD:
                state_d = sync_mode_q ? ST_SYNC : ST_PREAMBLE;
            ST_PREAMBLE:
                if (elem_tick && phase_q == `PREAMBLE_ELEMS - 8'h01) begin
                    state_d = ST_HEADER;
                end
            ST_HEADER:
                if (elem_tick && phase_q == `HEADER_ELEMS - 8'h01) begin
                    state_d = ST_DATA;
                end
            ST_DATA:
                if (word_done) state_d = ST_GUARD;
            ST_GUARD:
                if (elem_tick && phase_q == `GUARD_ELEMS - 8'h01) begin
                    state_d = (btn_now != '0) ? ST_BUILD : ST_IDLE;
                end
            ST_SYNC:
                if (bit_pop && sent_q == `SYNC_BITS - 7'h01) begin
                    state_d = ST_SYNC_END;
                end
            ST_SYNC_END:
                if (clk_fall) state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
        if (abort) state_d = ST_DEBOUNCE;
    end

    // symbol shape: high 1 element for one, 2 for zero
    wire data_level = (sub_q == 2'h0)
                      || ((sub_q == 2'h1) && !fifo_bit);
    logic pwm_d;
    always_comb begin
        case (state_q)
            ST_PREAMBLE: pwm_d = !phase_q[0];
            ST_DATA:     pwm_d = data_level;
            ST_SYNC:     pwm_d = clk_rise ? fifo_bit : pwm_q;
            default:     pwm_d = 1'b0;
        endcase
        if (blank_q && tx_timed) pwm_d = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            clk_prev_q  <= 1'b0;
            pwm_q       <= 1'b0;
            oe_n_q      <= 1'b1;
        end else begin
            state_q     <= state_d;
            clk_prev_q  <= clk_pin;
            pwm_q       <= pwm_d;
            oe_n_q      <= !(tx_timed || state_q inside {ST_SYNC,
                                                         ST_SYNC_END});
        end
    end

    // timers and counters
    always_ff @(posedge ref_clk) begin
        if (reset || state_q != state_d) begin
            wait_q  <= '0;
            elem_q  <= '0;
            phase_q <= '0;
            sub_q   <= '0;
        end else begin
            wait_q  <= wait_q + 24'h00_0001;
            elem_q  <= elem_tick ? '0 : elem_q + 24'h00_0001;
            if (elem_tick) begin
                phase_q <= phase_q + 8'h01;
                sub_q   <= (sub_q == `SYMBOL_ELEMS) ? 2'h0 : sub_q + 2'h1;
            end
        end
    end

    // assembly, fifo loading, mode and blanking
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            btn_q       <= '0;
            sync_mode_q <= 1'b0;
            blank_q     <= 1'b0;
            load_q      <= '0;
            sent_q      <= '0;
            word_q      <= '0;
        end else begin
            if (state_q == ST_DEBOUNCE && state_d == ST_BUILD) begin
                btn_q <= btn_now;
            end
            if (state_q == ST_ENTRY && clk_fall) begin
                btn_q       <= {1'b0, btn_now[1:0]};
                sync_mode_q <= (btn_now[1:0] != '0);
            end
            if (state_q == ST_IDLE) sync_mode_q <= 1'b0;
            if (state_q == ST_BUILD) begin
                word_q <= word_new;
                load_q <= sync_mode_q ? `SYNC_BITS : `DATA_BITS;
                sent_q <= '0;
            end else if (abort) begin
                load_q <= '0;
            end else if (push && fifo_in_ready) begin
                word_q <= {1'b0, word_q[81:1]};
                load_q <= load_q - 7'h01;
            end
            if (bit_pop) sent_q <= sent_q + 7'h01;
            if (word_done) begin
                blank_q <= rate_select_bit && !blank_q;
            end else if (state_q == ST_IDLE) begin
                blank_q <= 1'b0;
            end
        end
    end

    // store writes: counter update and serial programming
    always_ff @(posedge ref_clk) begin
        if (state_q == ST_BUILD && !seed_req) begin
            store_q[`W_HOP_COUNT] <= hop_next;
        end
        if (state_q == ST_ENTRY && state_d == ST_PROG) begin
            for (int i = 0; i < `STORE_WORDS; i++) begin
                store_q[i] <= '0;
            end
        end
        if (state_q == ST_PROG && clk_fall && prog_bit_q == 4'hF) begin
            store_q[prog_idx_q] <= {data_pin, prog_sr_q[15:1]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || state_q != ST_PROG) begin
            prog_idx_q <= '0;
            prog_bit_q <= '0;
            prog_sr_q  <= '0;
        end else if (clk_fall) begin
            prog_sr_q  <= {data_pin, prog_sr_q[15:1]};
            prog_bit_q <= prog_bit_q + 4'h1;
            if (prog_bit_q == 4'hF) prog_idx_q <= prog_idx_q + 4'h1;
        end
    end

    assign pwm_pin    = '{out: pwm_q, oe_n: oe_n_q};
    assign powered_up = (state_q != ST_IDLE);

    property p_counter_step;
        @(posedge ref_clk) disable iff (reset)
        (state_q == ST_BUILD && !seed_req)
            |=> store_q[`W_HOP_COUNT] == $past(hop) + 16'h0001;
    endproperty
    a_counter_step: assert property (p_counter_step)
        else $error("hop counter not advanced by one");

    property p_seed_sent;
        @(posedge ref_clk) disable iff (reset)
        (state_q == ST_BUILD && btn_q == `ALL_BUTTONS)
            |=> word_q[31:0] == $past(seed);
    endproperty
    a_seed_sent: assert property (p_seed_sent)
        else $error("seed not placed in hopping part");

    property p_serial_field;
        @(posedge ref_clk) disable iff (reset)
        state_q == ST_BUILD |=> word_q[59:32] == $past(serial[27:0])
                                && word_q[65] == 1'b1;
    endproperty
    a_serial_field: assert property (p_serial_field)
        else $error("fixed part serial field wrong");

    property p_low_flag;
        @(posedge ref_clk) disable iff (reset)
        state_q == ST_BUILD |=> word_q[64] == $past(low_supply_flag);
    endproperty
    a_low_flag: assert property (p_low_flag)
        else $error("low supply flag mismatch");

    property p_abort;
        @(posedge ref_clk) disable iff (reset)
        (tx_timed && !sync_mode_q && new_press)
            |=> state_q == ST_DEBOUNCE && !fifo_out_valid;
    endproperty
    a_abort: assert property (p_abort)
        else $error("new button did not abort the word");

    property p_complete;
        @(posedge ref_clk) disable iff (reset)
        (state_q == ST_DATA && btn_now == '0 && !word_done)
            |=> state_q == ST_DATA;
    endproperty
    a_complete: assert property (p_complete)
        else $error("word cut short after release");

    property p_wake;
        @(posedge ref_clk) disable iff (reset)
        (state_q == ST_IDLE && btn_now != '0) |=> state_q == ST_DEBOUNCE
            ##1 (state_q == ST_DEBOUNCE)[*8];
    endproperty
    a_wake: assert property (p_wake)
        else $error("debounce not held after wake");

    property p_word_len;
        @(posedge ref_clk) disable iff (reset)
        (word_done && !abort) |=> state_q == ST_GUARD && load_q == '0
            && !fifo_out_valid;
    endproperty
    a_word_len: assert property (p_word_len)
        else $error("data part not 66 bits");

    property p_symbol_head;
        @(posedge ref_clk) disable iff (reset)
        (state_q == ST_DATA && sub_q == 2'h0 && !blank_q
         && state_d == ST_DATA) |=> pwm_pin.out && !pwm_pin.oe_n;
    endproperty
    a_symbol_head: assert property (p_symbol_head)
        else $error("symbol does not open high");

endmodule

// file: src/hop_encoder_map.svh
/*
 * constants of the code hopping encoder: store layout, option word fields,
 * code word layout and timing figures.
 * assumes a single 250 MHz reference clock.
 */
`ifndef HOP_ENCODER_MAP_SVH
`define HOP_ENCODER_MAP_SVH

// store geometry and word indices
`define STORE_WORDS      12
`define W_KEY0           4'h0
`define W_KEY1           4'h1
`define W_KEY2           4'h2
`define W_KEY3           4'h3
`define W_HOP_COUNT      4'h4
`define W_SPARE_A        4'h5
`define W_SERIAL_LO      4'h6
`define W_SERIAL_HI      4'h7
`define W_SEED_LO        4'h8
`define W_SEED_HI        4'h9
`define W_SPARE_B        4'hA
`define W_OPTION         4'hB

// option word fields
`define OPT_DISC_MSB     11
`define OPT_VSEL_BIT     12
`define OPT_RATE_BIT     13

// code word layout
`define SERIAL_TX_BITS   28
`define DATA_BITS        7'h42
`define SYNC_BITS        7'h52
`define EXTRA_BITS       16
`define ALL_BUTTONS      3'h7

// timing
`define CLK_MHZ          250
`define ELEM_SLOW_US     400
`define ELEM_FAST_US     200
`define DEBOUNCE_US      10000
`define PROG_SETUP_US    3500
`define PREAMBLE_ELEMS   8'h17
`define HEADER_ELEMS     8'h0A
`define GUARD_ELEMS      8'h27
`define SYMBOL_ELEMS     2'h2

`endif

// file: src/hop_encoder_pkg.sv
/*
 * types of the code hopping encoder.
 * constants come from hop_encoder_map.svh.
 */
package hop_encoder_pkg;

    typedef enum logic [10:0] {
        ST_IDLE     = 11'b000_0000_0001,
        ST_DEBOUNCE = 11'b000_0000_0010,
        ST_ENTRY    = 11'b000_0000_0100,
        ST_PROG     = 11'b000_0000_1000,
        ST_BUILD    = 11'b000_0001_0000,
        ST_PREAMBLE = 11'b000_0010_0000,
        ST_HEADER   = 11'b000_0100_0000,
        ST_DATA     = 11'b000_1000_0000,
        ST_GUARD    = 11'b001_0000_0000,
        ST_SYNC     = 11'b010_0000_0000,
        ST_SYNC_END = 11'b100_0000_0000
    } enc_state_t;

    // fixed part of the code word, msb sent last
    typedef struct packed {
        logic        fixed_one;
        logic        low_supply_flag;
        logic [3:0]  buttons;
        logic [27:0] serial;
    } fixed_part_t;

    // pwm pin as two signals
    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_drive_t;

endpackage

// file: testbench/hop_encoder_test.sv
/*
 * self-checking bench of the code hopping encoder.
 * assumes shortened timing parameters and the rf stage model.
 */
`timescale 1ns/1ns
module hop_encoder_test;
    import hop_encoder_pkg::*;
    logic        ref_clk    = 1'b0;
    logic        reset      = 1'b1;
    logic        btn_a      = 1'b0;
    logic        btn_b      = 1'b0;
    logic        btn_c      = 1'b0;
    logic        host_level = 1'b0;
    logic        low_6v     = 1'b0;
    logic        low_9v     = 1'b0;
    logic        pwm_in;
    logic        powered_up;
    logic        word_valid;
    logic [65:0] word;
    logic [65:0] got;
    logic [81:0] sync_bits;
    pin_drive_t  pwm_pin;
    logic [15:0] store [12];
    int          err_total       = 0;
    int          samples_checked = 0;
    int          n;

    always #2 ref_clk = ~ref_clk;

    hop_encoder #(.ELEM_SLOW_CYC(20), .ELEM_FAST_CYC(10),
        .DEBOUNCE_CYC(40), .PROG_SETUP_CYC(20)) i_hop_encoder (
        .ref_clk(ref_clk), .reset(reset), .button_input_a(btn_a),
        .button_input_b(btn_b), .button_input_c_clock(btn_c),
        .pwm_in(pwm_in), .pwm_pin(pwm_pin), .below_trip_6v(low_6v),
        .below_trip_9v(low_9v), .powered_up(powered_up));

    rf_stage_model #(.ELEM(20)) i_rf_stage_model (
        .ref_clk(ref_clk), .pwm_pin(pwm_pin), .host_level(host_level),
        .pwm_in(pwm_in), .word(word), .word_valid(word_valid));

    function automatic logic [65:0] exp_word(logic [31:0] lo,
                                             logic [3:0] btn, logic flag);
        return {1'b1, flag, btn, store[7][11:0], store[6], lo};
    endfunction

    function automatic logic sig(int k);
        case (k)
            0: return word_valid;
            1: return ~powered_up;
            2: return ~pwm_pin.oe_n;
            default: return pwm_pin.out;
        endcase
    endfunction

    task automatic check(string what, logic [65:0] seen, logic [65:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // bounded wait; a run-out counts as a mismatch
    task automatic wait_on(int k, int lim);
        int m;
        m = 0;
        while (sig(k) !== 1'b1 && m < lim) begin
            cyc(1);
            m++;
        end
        check("wait", 66'(m < lim), 66'h1);
        got = word;
    endtask

    // outside clock kept slow against the input synchronisers
    task automatic clk_pulse();
        btn_c = 1'b1;
        cyc(6);
        btn_c = 1'b0;
        cyc(6);
    endtask

    task automatic entry(logic a_v, logic b_v);
        btn_c = 1'b1;
        cyc(30);
        host_level = 1'b1;
        cyc(8);
        btn_a = a_v;
        btn_b = b_v;
        cyc(4);
        btn_c = 1'b0;
        cyc(4);
        host_level = 1'b0;
        cyc(20);
    endtask

    task automatic program_store();
        entry(1'b0, 1'b0);
        for (int w = 0; w < 12; w++) begin
            for (int i = 0; i < 16; i++) begin
                host_level = store[w][i];
                clk_pulse();
            end
        end
        host_level = 1'b0;
        cyc(20);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #320000;
        err_total++;
        end_sim();
    end

    initial begin
        store = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h0010,
                  16'h0000, 16'h4321, 16'hfabc, 16'ha5c3, 16'h3c5a,
                  16'h0000, 16'h0a55};
        cyc(12);
        reset = 1'b0;
        cyc(2);
        program_store();
        // seed word survives release, 9 v trip ignored
        {btn_a, btn_b, btn_c} = 3'h7;
        low_9v = 1'b1;
        wait_on(2, 200);
        {btn_a, btn_b, btn_c} = 3'h0;
        wait_on(0, 9000);
        check("seed", got, exp_word({store[9], store[8]}, 4'hf, 1'b0));
        wait_on(1, 2000);
        // held buttons repeat, 6 v trip reported
        {low_6v, low_9v} = 2'b10;
        {btn_a, btn_b, btn_c} = 3'h7;
        wait_on(0, 9000);
        check("low", got, exp_word({store[9], store[8]}, 4'hf, 1'b1));
        wait_on(0, 9000);
        check("again", got, exp_word({store[9], store[8]}, 4'hf, 1'b1));
        {btn_a, btn_b, btn_c} = 3'h0;
        low_6v = 1'b0;
        wait_on(1, 9000);
        // added buttons abort and rebuild
        btn_a = 1'b1;
        wait_on(2, 200);
        cyc(40);
        {btn_b, btn_c} = 2'b11;
        wait_on(0, 12000);
        check("abort", got, exp_word({store[9], store[8]}, 4'hf, 1'b0));
        {btn_a, btn_b, btn_c} = 3'h0;
        wait_on(1, 9000);
        // clocked mode, button code from entry edge
        entry(1'b0, 1'b1);
        // code already latched at the entry edge
        btn_b = 1'b0;
        for (int i = 0; i < 82; i++) begin
            btn_c = 1'b1;
            cyc(6);
            sync_bits[i] = pwm_pin.out;
            btn_c = 1'b0;
            cyc(6);
        end
        got = exp_word(32'h0000_0000, 4'h2, 1'b0);
        check("clocked", 66'(sync_bits[81:32]), 66'({16'h0000, got[65:32]}));
        check("serial", 66'(sync_bits[59:32]),
              66'({store[7][11:0], store[6]}));
        check("code", 66'(sync_bits[63:60]), 66'h2);
        wait_on(1, 400);
        // fast rate halves the element
        store[11] = 16'h2a55;
        program_store();
        btn_a = 1'b1;
        wait_on(3, 400);
        n = 0;
        while (pwm_pin.out === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        check("fast element", 66'(n), 66'ha);
        // held button: second word blanked, third lies past the window
        n = 0;
        repeat (5200) begin
            cyc(1);
            n += int'(word_valid === 1'b1);
        end
        check("blanked words", 66'(n), 66'h1);
        btn_a = 1'b0;
        wait_on(1, 12000);
        end_sim();
    end
endmodule

// file: testbench/rf_stage_model.sv
/*
 * rf stage model: resolves the pwm pin and decodes pulse-width words.
 * assumes ELEM clock cycles per basic element and a pull-down on the pin.
 */
`timescale 1ns/1ns
module rf_stage_model #(
    parameter int ELEM = 20
) (
    // clock
    input  wire logic                        ref_clk,
    // pin
    input  wire hop_encoder_pkg::pin_drive_t pwm_pin,
    input  wire logic                        host_level,
    output logic                             pwm_in,
    // decoded word
    output logic [65:0]                      word,
    output logic                             word_valid
);
    import hop_encoder_pkg::*;
    int          hi_run = 0;
    int          lo_run = 0;
    int          nbits  = 0;
    logic [65:0] acc    = '0;
    // host level only reaches the pin while the device lets go
    assign pwm_in = pwm_pin.oe_n ? host_level : pwm_pin.out;
    initial word_valid = 1'b0;
    always @(posedge ref_clk) begin
        word_valid <= 1'b0;
        if (pwm_in) begin
            hi_run++;
            lo_run = 0;
        end else begin
            // short high reads as one, long high as zero
            if (hi_run > 0 && nbits < 66) begin
                acc[nbits] = (hi_run < 3 * ELEM / 2);
            end
            if (hi_run > 0) begin
                nbits++;
            end
            hi_run = 0;
            lo_run++;
            // a long low ends preamble or data alike
            if (lo_run == 3 * ELEM) begin
                if (nbits == 66) begin
                    word       <= acc;
                    word_valid <= 1'b1;
                end
                nbits = 0;
            end
        end
    end
endmodule
